/* core/llbs_pkg.sv */
// package for the ladder bit-logic evaluation core
// assumes a synchronous program memory with one cycle of read latency
package llbs_pkg;

   // ----------------------------------------------------------------
   // instruction word layout
   // ----------------------------------------------------------------
   localparam int OPC_W = 8;
   localparam int OPERAND_W = 16;
   localparam int INSTR_W = OPC_W + OPERAND_W;
   localparam int OPC_LSB = OPERAND_W;
   localparam int OPERAND_LSB = 0;

   // ----------------------------------------------------------------
   // default sizes
   // ----------------------------------------------------------------
   localparam int PROG_AW_DEF = 10;
   localparam int STACK_DEPTH_DEF = 8;

   // ----------------------------------------------------------------
   // function codes; end keeps its fixed code 01
   // ----------------------------------------------------------------
   typedef enum logic [OPC_W-1:0] {
      LLBS_OP_NOP = 8'h00,
      LLBS_OP_END = 8'h01,
      LLBS_OP_LOAD = 8'h10,
      LLBS_OP_LOAD_INV = 8'h11,
      LLBS_OP_AND = 8'h12,
      LLBS_OP_AND_INV = 8'h13,
      LLBS_OP_OR = 8'h14,
      LLBS_OP_OR_INV = 8'h15,
      LLBS_OP_BLOCK_AND = 8'h16,
      LLBS_OP_BLOCK_OR = 8'h17,
      LLBS_OP_OUT = 8'h18,
      LLBS_OP_OUT_INV = 8'h19
   } llbs_opcode_e;

   // ----------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      LLBS_ST_SEEK_WAIT = 3'b000,
      LLBS_ST_SEEK_CHECK = 3'b001,
      LLBS_ST_FETCH = 3'b010,
      LLBS_ST_LATCH = 3'b011,
      LLBS_ST_EXEC = 3'b100
   } llbs_state_e;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic RST_COND = 1'b0;
   localparam logic RST_LINE_OPEN = 1'b0;

endpackage : llbs_pkg

/* core/llbs_cond_stack.sv */
// saved execution condition buffer, last in first out
// assumes the caller never pushes and pops in the same cycle
`timescale 1ns/1ns
module llbs_cond_stack #(
   parameter int DEPTH = llbs_pkg::STACK_DEPTH_DEF
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clear,
   input wire logic push,
   input wire logic pop,
   input wire logic push_data,
   output logic top,
   output logic empty,
   output logic full
);

   localparam int CNT_W = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0] bits;
      logic [CNT_W-1:0] count;
   } llbs_stack_s;

   llbs_stack_s st_reg;
   llbs_stack_s st_next;

   // ----------------------------------------------------------------
   // shift register: newest entry always in bit 0
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      if (clear) begin
         st_next.bits = '0;
         st_next.count = '0;
      end else if (push && !full) begin
         // a push into a full buffer is dropped; caller flags it
         st_next.bits = {st_reg.bits[DEPTH-2:0], push_data};
         st_next.count = st_reg.count + CNT_W'(1);
      end else if (pop && !empty) begin
         st_next.bits = {1'b0, st_reg.bits[DEPTH-1:1]};
         st_next.count = st_reg.count - CNT_W'(1);
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // status straight from the held count
   assign top = st_reg.bits[0];
   assign empty = (st_reg.count == '0);
   assign full = (st_reg.count == CNT_W'(DEPTH));

endmodule : llbs_cond_stack

/* core/llbs_core.sv */
// ladder bit-logic evaluation core: scans a program of bit instructions
// assumes program memory and bit image run on CLOCK, memory reads one cycle late
`timescale 1ns/1ns

module llbs_core #(
   parameter int PROG_AW = llbs_pkg::PROG_AW_DEF,
   parameter int STACK_DEPTH = llbs_pkg::STACK_DEPTH_DEF
) (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   output logic [PROG_AW-1:0] PROG_ADDR,
   input wire logic [llbs_pkg::INSTR_W-1:0] PROG_DATA,
   output logic [llbs_pkg::OPERAND_W-1:0] BIT_RD_ADDR,
   input wire logic BIT_RD_DATA,
   output logic BIT_WR_EN,
   output logic [llbs_pkg::OPERAND_W-1:0] BIT_WR_ADDR,
   output logic BIT_WR_DATA,
   output logic SCAN_END,
   output logic RUNNING,
   output logic NO_END_FOUND,
   output logic STACK_ERROR,
   output logic CONDITION
);

   // ----------------------------------------------------------------
   // state of the sequencer
   // ----------------------------------------------------------------
   typedef struct packed {
      llbs_pkg::llbs_state_e state;
      logic [PROG_AW-1:0] pc;
      logic [llbs_pkg::INSTR_W-1:0] instr;
      logic cond;
      logic line_open;
      logic running;
      logic no_end;
      logic err;
      logic scan_end;
      logic wr_en;
      logic [llbs_pkg::OPERAND_W-1:0] wr_addr;
      logic wr_data;
   } llbs_core_s;

   llbs_core_s core_reg;
   llbs_core_s core_next;

   logic stk_clear;
   logic stk_push;
   logic stk_pop;
   logic stk_top;
   logic stk_empty;
   logic stk_full;

   localparam logic [PROG_AW-1:0] PC_LAST = {PROG_AW{1'b1}};

   // ----------------------------------------------------------------
   // field helpers
   // ----------------------------------------------------------------
   function automatic logic [llbs_pkg::OPC_W-1:0] opc_of(
      input logic [llbs_pkg::INSTR_W-1:0] w
   );
      opc_of = w[llbs_pkg::OPC_LSB +: llbs_pkg::OPC_W];
   endfunction : opc_of

   function automatic logic [llbs_pkg::OPERAND_W-1:0] operand_of(
      input logic [llbs_pkg::INSTR_W-1:0] w
   );
      operand_of = w[llbs_pkg::OPERAND_LSB +: llbs_pkg::OPERAND_W];
   endfunction : operand_of

   // ----------------------------------------------------------------
   // saved-condition buffer
   // ----------------------------------------------------------------
   llbs_cond_stack #(
      .DEPTH(STACK_DEPTH)
   ) u_stack (
      .clock(CLOCK),
      .sys_rst(SYS_RST),
      .clear(stk_clear),
      .push(stk_push),
      .pop(stk_pop),
      .push_data(core_reg.cond),
      .top(stk_top),
      .empty(stk_empty),
      .full(stk_full)
   );

   // ----------------------------------------------------------------
   // next-state logic: seek end, then fetch, latch, execute
   // ----------------------------------------------------------------
   always_comb begin
      logic [llbs_pkg::OPC_W-1:0] opc;
      opc = opc_of(core_reg.instr);
      core_next = core_reg;
      core_next.scan_end = 1'b0;
      core_next.wr_en = 1'b0;
      stk_clear = 1'b0;
      stk_push = 1'b0;
      stk_pop = 1'b0;
      case (core_reg.state)
         llbs_pkg::LLBS_ST_SEEK_WAIT: begin
            // memory word for pc arrives next cycle
            core_next.state = llbs_pkg::LLBS_ST_SEEK_CHECK;
         end
         llbs_pkg::LLBS_ST_SEEK_CHECK: begin
            // nothing runs until an end is known to exist
            if (opc_of(PROG_DATA) == llbs_pkg::LLBS_OP_END) begin
               core_next.pc = '0;
               core_next.no_end = 1'b0;
               core_next.running = 1'b1;
               core_next.state = llbs_pkg::LLBS_ST_FETCH;
            end else begin
               if (core_reg.pc == PC_LAST) begin
                  core_next.no_end = 1'b1;
               end
               core_next.pc = core_reg.pc + PROG_AW'(1);
               core_next.state = llbs_pkg::LLBS_ST_SEEK_WAIT;
            end
         end
         llbs_pkg::LLBS_ST_FETCH: begin
            core_next.state = llbs_pkg::LLBS_ST_LATCH;
         end
         llbs_pkg::LLBS_ST_LATCH: begin
            // holding the word lets the bit address come from a flop
            core_next.instr = PROG_DATA;
            core_next.state = llbs_pkg::LLBS_ST_EXEC;
         end
         llbs_pkg::LLBS_ST_EXEC: begin
            core_next.state = llbs_pkg::LLBS_ST_FETCH;
            core_next.pc = core_reg.pc + PROG_AW'(1);
            case (opc)
               llbs_pkg::LLBS_OP_LOAD, llbs_pkg::LLBS_OP_LOAD_INV: begin
                  if (core_reg.line_open) begin
                     stk_push = 1'b1;
                     if (stk_full) begin
                        core_next.err = 1'b1;
                     end
                  end else begin
                     // fresh line: stale entries are dropped, nothing saved
                     stk_clear = 1'b1;
                  end
                  core_next.cond = BIT_RD_DATA ^ (opc == llbs_pkg::LLBS_OP_LOAD_INV);
                  core_next.line_open = 1'b1;
               end
               llbs_pkg::LLBS_OP_AND: begin
                  core_next.cond = core_reg.cond & BIT_RD_DATA;
               end
               llbs_pkg::LLBS_OP_AND_INV: begin
                  core_next.cond = core_reg.cond & ~BIT_RD_DATA;
               end
               llbs_pkg::LLBS_OP_OR: begin
                  core_next.cond = core_reg.cond | BIT_RD_DATA;
               end
               llbs_pkg::LLBS_OP_OR_INV: begin
                  core_next.cond = core_reg.cond | ~BIT_RD_DATA;
               end
               llbs_pkg::LLBS_OP_BLOCK_AND, llbs_pkg::LLBS_OP_BLOCK_OR: begin
                  // operand field never looked at
                  if (stk_empty) begin
                     core_next.err = 1'b1;
                  end else begin
                     stk_pop = 1'b1; // newest saved entry
                     if (opc == llbs_pkg::LLBS_OP_BLOCK_AND) begin
                        core_next.cond = core_reg.cond & stk_top;
                     end else begin
                        core_next.cond = core_reg.cond | stk_top;
                     end
                  end
               end
               llbs_pkg::LLBS_OP_OUT, llbs_pkg::LLBS_OP_OUT_INV: begin
                  // rewritten each scan, so the bit follows the condition
                  core_next.wr_en = 1'b1;
                  core_next.wr_addr = operand_of(core_reg.instr);
                  core_next.wr_data = core_reg.cond ^ (opc == llbs_pkg::LLBS_OP_OUT_INV);
                  core_next.line_open = 1'b0; // next load starts a new line
               end
               llbs_pkg::LLBS_OP_END: begin
                  core_next.pc = '0;
                  core_next.scan_end = 1'b1;
                  core_next.line_open = 1'b0;
                  stk_clear = 1'b1;
               end
               default: begin
                  // no-op and unknown codes fall through
                  if (core_reg.pc == PC_LAST) begin
                     // end vanished from memory: stop and search again
                     core_next.running = 1'b0;
                     core_next.pc = '0;
                     core_next.state = llbs_pkg::LLBS_ST_SEEK_WAIT;
                  end
               end
            endcase
            if (opc != llbs_pkg::LLBS_OP_END && core_reg.pc == PC_LAST) begin
               core_next.running = 1'b0;
               core_next.pc = '0;
               core_next.state = llbs_pkg::LLBS_ST_SEEK_WAIT;
            end
         end
         default: begin
            core_next.state = llbs_pkg::LLBS_ST_SEEK_WAIT;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge CLOCK or posedge SYS_RST) begin
      if (SYS_RST) begin
         core_reg <= '0;
         core_reg.state <= llbs_pkg::LLBS_ST_SEEK_WAIT;
         core_reg.cond <= llbs_pkg::RST_COND;
         core_reg.line_open <= llbs_pkg::RST_LINE_OPEN;
      end else begin
         core_reg <= core_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all from flops
   // ----------------------------------------------------------------
   assign PROG_ADDR = core_reg.pc;
   assign BIT_RD_ADDR = operand_of(core_reg.instr);
   assign BIT_WR_EN = core_reg.wr_en;
   assign BIT_WR_ADDR = core_reg.wr_addr;
   assign BIT_WR_DATA = core_reg.wr_data;
   assign SCAN_END = core_reg.scan_end;
   assign RUNNING = core_reg.running;
   assign NO_END_FOUND = core_reg.no_end;
   assign STACK_ERROR = core_reg.err; // sticky until reset
   assign CONDITION = core_reg.cond;

endmodule : llbs_core

/* bench/llbs_core_properties.sv */
// port-level assertions for the ladder bit-logic core
// assumes bind to llbs_core, one clock domain, memory read one cycle late
`timescale 1ns/1ns
module llbs_core_properties #(
   parameter int PROG_AW = 10
) (
   input wire logic CLOCK,
   input wire logic SYS_RST,
   input wire logic [PROG_AW-1:0] PROG_ADDR,
   input wire logic [llbs_pkg::INSTR_W-1:0] PROG_DATA,
   input wire logic BIT_WR_EN,
   input wire logic [llbs_pkg::OPERAND_W-1:0] BIT_WR_ADDR,
   input wire logic BIT_WR_DATA,
   input wire logic SCAN_END,
   input wire logic RUNNING,
   input wire logic NO_END_FOUND,
   input wire logic STACK_ERROR,
   input wire logic CONDITION
);
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   // one domain, so clock and reset are given once
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);

   scan_restart_a: assert property (SCAN_END |-> PROG_ADDR == '0)
      else $error("scan end without return to address zero");
   no_end_idle_a: assert property (!RUNNING |-> !BIT_WR_EN && !SCAN_END)
      else $error("activity without an end instruction");
   scan_gap_a: assert property (SCAN_END |=> !SCAN_END [*2])
      else $error("scan end pulses too close");
   end_found_a: assert property (RUNNING && $past(RUNNING, 2) |-> !NO_END_FOUND)
      else $error("missing end flag while running");
   addr_hold_a: assert property (RUNNING && $changed(PROG_ADDR) |=>
      $stable(PROG_ADDR) [*2])
      else $error("instruction address not held three cycles");
   error_sticky_a: assert property (STACK_ERROR |=> STACK_ERROR)
      else $error("stack error flag dropped");
   write_pulse_a: assert property (BIT_WR_EN |=> !BIT_WR_EN)
      else $error("bit write longer than one cycle");
   // the memory word still shows the output instruction in the write cycle
   out_value_a: assert property (BIT_WR_EN |->
      BIT_WR_DATA == (CONDITION ^ PROG_DATA[16]) && BIT_WR_ADDR == PROG_DATA[15:0])
      else $error("output bit value or address wrong");
endmodule : llbs_core_properties

bind llbs_core llbs_core_properties #(.PROG_AW(PROG_AW)) u_props (.CLOCK(CLOCK),
   .SYS_RST(SYS_RST), .PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA), .BIT_WR_EN(BIT_WR_EN),
   .BIT_WR_ADDR(BIT_WR_ADDR), .BIT_WR_DATA(BIT_WR_DATA), .SCAN_END(SCAN_END),
   .RUNNING(RUNNING), .NO_END_FOUND(NO_END_FOUND), .STACK_ERROR(STACK_ERROR),
   .CONDITION(CONDITION));

/* bench/llbs_prog_model.sv */
// program memory and bit image standing beside the core
// assumes the bench loads mem directly while the core is in reset; input bits are also set directly during a run
`timescale 1ns/1ns
module llbs_prog_model #(
   parameter int PROG_AW = 4
) (
   input wire logic clock,
   input wire logic [PROG_AW-1:0] prog_addr,
   output logic [llbs_pkg::INSTR_W-1:0] prog_data,
   input wire logic [llbs_pkg::OPERAND_W-1:0] bit_rd_addr,
   output logic bit_rd_data,
   input wire logic bit_wr_en,
   input wire logic [llbs_pkg::OPERAND_W-1:0] bit_wr_addr,
   input wire logic bit_wr_data
);
   logic [llbs_pkg::INSTR_W-1:0] mem [0:(1<<PROG_AW)-1];
   logic bits [0:65535];

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   // read one cycle late, like a synchronous memory
   always @(posedge clock) prog_data <= mem[prog_addr];
   // plain always, since the bench also writes input bits
   always @(posedge clock) if (bit_wr_en) bits[bit_wr_addr] <= bit_wr_data;
   assign bit_rd_data = bits[bit_rd_addr];
endmodule : llbs_prog_model

/* bench/ladder_logic_block_stack_test.sv */
// self-checking bench for the ladder bit-logic core
// assumes llbs_pkg, llbs_core and the program model are compiled first
`timescale 1ns/1ns
module ladder_logic_block_stack_test;
   localparam int AW = 4;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [AW-1:0] prog_addr;
   logic [llbs_pkg::INSTR_W-1:0] prog_data;
   logic [15:0] bit_rd_addr, bit_wr_addr;
   logic bit_rd_data, bit_wr_en, bit_wr_data, scan_end, running, no_end_found;
   logic stack_error, condition;
   int err_count = 0;
   int n_checks = 0;

   always #2 clock = ~clock;

   llbs_core #(.PROG_AW(AW), .STACK_DEPTH(8)) dut (.CLOCK(clock), .SYS_RST(sys_rst),
      .PROG_ADDR(prog_addr), .PROG_DATA(prog_data), .BIT_RD_ADDR(bit_rd_addr),
      .BIT_RD_DATA(bit_rd_data), .BIT_WR_EN(bit_wr_en), .BIT_WR_ADDR(bit_wr_addr),
      .BIT_WR_DATA(bit_wr_data), .SCAN_END(scan_end), .RUNNING(running),
      .NO_END_FOUND(no_end_found), .STACK_ERROR(stack_error), .CONDITION(condition));
   llbs_prog_model #(.PROG_AW(AW)) u_mem (.clock(clock), .prog_addr(prog_addr),
      .prog_data(prog_data), .bit_rd_addr(bit_rd_addr), .bit_rd_data(bit_rd_data),
      .bit_wr_en(bit_wr_en), .bit_wr_addr(bit_wr_addr), .bit_wr_data(bit_wr_data));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task put(input int a, input llbs_pkg::llbs_opcode_e op, input logic [15:0] opd);
      u_mem.mem[a] = {op, opd};
   endtask : put

   // reset held while the program is swapped, memory must not move in a run
   task restart();
      @(negedge clock);
      sys_rst = 1'b1;
      for (int i = 0; i < (1 << AW); i++) put(i, llbs_pkg::LLBS_OP_NOP, 16'h0000);
      for (int i = 0; i < 16; i++) u_mem.bits[i] = 1'b0;
   endtask : restart

   task go();
      repeat (16) @(negedge clock);
      sys_rst = 1'b0;
   endtask : go

   // bounded wait for the end-of-scan pulse
   task wait_scan();
      int n;
      n = 0;
      @(negedge clock);
      while (scan_end !== 1'b1 && n < 400) begin
         @(negedge clock);
         n++;
      end
      check({15'h0, scan_end}, 16'h0001);
   endtask : wait_scan

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // blank memory: sweep of 16 words at 2 cycles each finds nothing
   task no_end_test();
      restart();
      go();
      repeat (60) @(negedge clock);
      check({15'h0, no_end_found}, 16'h0001);
      check({15'h0, running}, 16'h0000);
   endtask : no_end_test

   // two lines with nested blocks, every input combination
   task logic_test();
      logic [7:0] b;
      logic e_a;
      logic e_b;
      restart();
      put(0, llbs_pkg::LLBS_OP_LOAD, 16'h0000);
      put(1, llbs_pkg::LLBS_OP_OR_INV, 16'h0001);
      put(2, llbs_pkg::LLBS_OP_LOAD_INV, 16'h0002);
      put(3, llbs_pkg::LLBS_OP_AND, 16'h0003);
      put(4, llbs_pkg::LLBS_OP_BLOCK_AND, 16'hffff); // junk operand must be ignored
      put(5, llbs_pkg::LLBS_OP_OUT, 16'h000a);
      put(6, llbs_pkg::LLBS_OP_LOAD, 16'h0004);
      put(7, llbs_pkg::LLBS_OP_LOAD, 16'h0005);
      put(8, llbs_pkg::LLBS_OP_LOAD, 16'h0006);
      put(9, llbs_pkg::LLBS_OP_AND_INV, 16'h0007);
      put(10, llbs_pkg::LLBS_OP_BLOCK_OR, 16'h0000); // newest pair first
      put(11, llbs_pkg::LLBS_OP_BLOCK_AND, 16'h0000);
      put(12, llbs_pkg::LLBS_OP_OUT_INV, 16'h000b);
      put(13, llbs_pkg::LLBS_OP_END, 16'h0000);
      put(14, llbs_pkg::LLBS_OP_LOAD_INV, 16'h000f);
      put(15, llbs_pkg::LLBS_OP_OUT, 16'h000c); // beyond end, never run
      go();
      for (int v = 0; v < 256; v++) begin
         b = v[7:0];
         wait_scan();
         for (int i = 0; i < 8; i++) u_mem.bits[i] = b[i];
         wait_scan();
         // expected outputs straight from the ladder, not from the core
         e_a = (b[0] | ~b[1]) & ~b[2] & b[3];
         e_b = ~(b[4] & (b[6] & ~b[7] | b[5]));
         check({15'h0, u_mem.bits[10]}, {15'h0, e_a});
         check({15'h0, u_mem.bits[11]}, {15'h0, e_b});
         check({15'h0, u_mem.bits[12]}, 16'h0000);
         check({15'h0, stack_error}, 16'h0000);
      end
   endtask : logic_test

   // one fresh load plus n-1 pushes into an 8-deep buffer
   task stack_test(input int n, input logic exp_err);
      restart();
      for (int i = 0; i < n; i++) put(i, llbs_pkg::LLBS_OP_LOAD, 16'h0000);
      put(n, llbs_pkg::LLBS_OP_OUT, 16'h000d);
      put(n + 1, llbs_pkg::LLBS_OP_END, 16'h0000);
      go();
      repeat (3) wait_scan();
      check({15'h0, stack_error}, {15'h0, exp_err});
   endtask : stack_test

   // combine with nothing saved: flag raised, condition kept; plain or lifts a 0 load
   task empty_test();
      restart();
      u_mem.bits[1] = 1'b1;
      put(0, llbs_pkg::LLBS_OP_LOAD, 16'h0000);
      put(1, llbs_pkg::LLBS_OP_OR, 16'h0001);
      put(2, llbs_pkg::LLBS_OP_BLOCK_OR, 16'h0000);
      put(3, llbs_pkg::LLBS_OP_OUT, 16'h000d);
      put(4, llbs_pkg::LLBS_OP_END, 16'h0000);
      go();
      repeat (2) wait_scan();
      check({15'h0, stack_error}, 16'h0001);
      check({15'h0, u_mem.bits[13]}, 16'h0001);
      check({15'h0, condition}, 16'h0001);
      check({15'h0, running}, 16'h0001);
      check({15'h0, no_end_found}, 16'h0000);
   endtask : empty_test

   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task end_of_test();
      $display("mismatches %0d of %0d checks", err_count, n_checks);
      if (err_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test

   // about 22k cycles expected, so 60k means a hang
   initial begin
      #(4 * 60000);
      err_count++;
      end_of_test();
   end

   initial begin
      no_end_test();
      logic_test();
      stack_test(9, 1'b0);
      stack_test(10, 1'b1);
      empty_test();
      end_of_test();
   end
endmodule : ladder_logic_block_stack_test
